// >>> verilog/failsafe_fault_pkg.sv
// constants, register map and types of the fail-safe fault manager
package failsafe_fault_pkg;
    localparam int NUM_CH = 24;
    // clock and timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int BLANK_STEP_NS = 1000;
    localparam int OPEN_DEG_NS = 10000;
    localparam int RETRY_PERIOD_MS = 10;
    localparam int BLANK_STEP_CYC = (BLANK_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int OPEN_DEG_CYC = (OPEN_DEG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RETRY_CYC_DEF = RETRY_PERIOD_MS * 1000000 / CLK_PERIOD_NS;
    // register byte addresses
    localparam logic [4:0] REG_CTRL = 5'h00;
    localparam logic [4:0] REG_CHK_EN = 5'h04;
    localparam logic [4:0] REG_FLAGS = 5'h08;
    localparam logic [4:0] REG_OPEN = 5'h0C;
    localparam logic [4:0] REG_STATUS = 5'h10;
    localparam logic [4:0] REG_RETRY = 5'h14;
    // control register fields
    localparam int CTRL_FCLR_BIT = 0;
    localparam int CTRL_RCLR_BIT = 1;
    localparam int CTRL_GROUP_BIT = 2;
    localparam int CTRL_LEVEL_LSB = 8;
    localparam int CTRL_PROBE_LSB = 16;
    localparam int CTRL_BLANK_LSB = 24;
    // flag register fields
    localparam int FLG_WARN = 0;
    localparam int FLG_UNDER = 1;
    localparam int FLG_REF = 2;
    localparam int FLG_HWARN = 3;
    localparam int FLG_HPROT = 4;
    localparam int FLG_RESTART = 5;
    localparam int FLG_OUT = 6;
    localparam int FLG_GLOBAL = 7;
    // status register fields
    localparam int ST_ERR = 0;
    localparam int ST_DIAG = 1;
    localparam int ST_REGUL = 2;
    // reset values
    localparam logic [4:0] LEVEL_RST = 5'h00;
    localparam logic [3:0] PROBE_RST = 4'h0;
    localparam logic [3:0] BLANK_RST = 4'h0;
    localparam logic [23:0] CHK_EN_RST = 24'hFFFFFF;
    localparam logic RESTART_FLAG_RST = 1'b1;
    // warning level code 0 stands for 4 V, one volt per code
    localparam logic [5:0] WARN_BASE_V = 6'h04;
    localparam logic [6:0] PROBE_MUL = 7'h04;
    localparam logic [6:0] PROBE_ADD = 7'h04;
    localparam int SYNC_W = 6;
    typedef enum logic {CH_RUN, CH_RETRY} chan_state_t;
endpackage

// >>> verilog/failsafe_fault_manager.sv
// fail-safe fault manager: flags, error pin, output shutoff and open-load retry
// How it works
// RULE1 - low supply sets warning and global flags
// RULE2 - flags latch; clear bit self-resets after write
// RULE3 - open detection only above warning level
// RULE4 - warning level 4 V to 35 V, 1 V steps
// RULE5 - undervoltage holds error pin, sets flags
// RULE6 - undervoltage disables outputs; recovery re-enables them
// RULE7 - reference open or short sets flags, pin
// RULE8 - reference fault turns outputs off while it lasts
// RULE9 - heat warning sets flags, no output action
// RULE10 - heat protection disables outputs, holds pin, flags
// RULE11 - below hysteresis resume outputs, release pin
// RULE12 - shutdown stops regulator, pin low, restart defaults
// RULE13 - restart clear bit clears restart, global flags
// RULE14 - open check only for long enough pulses
// RULE15 - open after blank plus deglitch: pin, flags
// RULE16 - open channel gets retry pulse every 10 ms
// RULE17 - retry current numerator is code*4+4 over 64
// RULE18 - retried channel recovers after qualified good level
// RULE19 - group option turns all channels off on fault
// RULE20 - disabled channel runs and reports no diagnostics
// RULE21 - comparator inputs synchronised and duration qualified; code qualifies only open_cmp, monitor inputs are only synchronised
//
// The Avalon-MM register port and the register addresses were left to the implementer.
`timescale 1ns/1ns
module failsafe_fault_manager
    import failsafe_fault_pkg::*;
#(
    parameter int unsigned RETRY_CYC = RETRY_CYC_DEF
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // avalon-mm slave
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // analog monitor inputs and pwm on-time
    input wire logic [5:0] supply_volts,
    input wire logic supply_under_det,
    input wire logic ref_open_det,
    input wire logic ref_short_det,
    input wire logic heat_warn_det,
    input wire logic heat_protect_det,
    input wire logic heat_shutdown_det,
    input wire logic [NUM_CH-1:0] open_cmp,
    input wire logic [NUM_CH-1:0] pwm_on,
    // outputs to drivers and pins
    output logic [NUM_CH-1:0] chan_enable,
    output logic [NUM_CH-1:0] retry_pulse,
    output logic [6:0] retry_current_num,
    output logic regulator_output,
    output logic diag_active,
    output logic err_pin_o,
    output logic err_pin_oe
);
    // configuration and pulses
    logic fault_clear_r;
    logic restart_clear_r;
    logic group_shutoff_option_r;
    logic [4:0] supply_warn_level_r;
    logic [3:0] probe_current_code_r;
    logic [3:0] blank_code_r;
    logic [NUM_CH-1:0] channel_check_enable_r;
    // flags
    logic supply_warn_flag_r;
    logic supply_under_flag_r;
    logic ref_flag_r;
    logic heat_warn_flag_r;
    logic heat_protect_flag_r;
    logic restart_flag_r;
    logic out_flag_r;
    logic global_flag_r;
    logic [NUM_CH-1:0] open_load_flag_r;
    // synchronisers
    logic [SYNC_W-1:0] mon_meta_r;
    logic [SYNC_W-1:0] mon_r;
    logic [NUM_CH-1:0] open_meta_r;
    logic [NUM_CH-1:0] open_r;
    logic warn_r;
    // channel state
    chan_state_t st_r [NUM_CH];
    logic [8:0] qual_cnt_r [NUM_CH];
    logic [NUM_CH-1:0] open_set;
    logic [NUM_CH-1:0] in_retry;
    logic [31:0] retry_cnt_r;
    // bus
    logic waitreq_r;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic wr_go;
    wire logic under_s = mon_r[0];
    wire logic ref_s = mon_r[1] | mon_r[2];
    wire logic hwarn_s = mon_r[3];
    wire logic hprot_s = mon_r[4];
    wire logic hshut_s = mon_r[5];
    wire logic [8:0] qual_lim = 9'(blank_code_r) * 9'(BLANK_STEP_CYC) + 9'(OPEN_DEG_CYC);
    wire logic [31:0] pulse_len = 32'(qual_lim) + 32'h00000002;
    wire logic retry_win = retry_cnt_r < pulse_len;
    wire logic all_off = under_s | ref_s | hprot_s | hshut_s;
    wire logic any_fault = |in_retry;
    // comparator synchronisers and supply warning compare [RULE21]
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            mon_meta_r <= '0;
            mon_r <= '0;
            open_meta_r <= '0;
            open_r <= '0;
            warn_r <= 1'b0;
        end else begin
            mon_meta_r <= {heat_shutdown_det, heat_protect_det, heat_warn_det,
                           ref_short_det, ref_open_det, supply_under_det};
            mon_r <= mon_meta_r;
            open_meta_r <= open_cmp;
            open_r <= open_meta_r;
            warn_r <= supply_volts < (6'(supply_warn_level_r) + WARN_BASE_V); // [RULE4]
        end
    end

    // avalon handshake: waitrequest drops one cycle after a request
    assign wr_go = avs_write & ~waitreq_r;
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            waitreq_r <= 1'b1;
            rdata_r <= '0;
        end else if ((avs_read | avs_write) & waitreq_r) begin
            waitreq_r <= 1'b0;
            rdata_r <= rdata_nxt;
        end else begin
            waitreq_r <= 1'b1;
        end
    end

    always_comb begin
        rdata_nxt = '0;
        if (avs_address == REG_CTRL) begin
            rdata_nxt[CTRL_GROUP_BIT] = group_shutoff_option_r;
            rdata_nxt[CTRL_LEVEL_LSB +: 5] = supply_warn_level_r;
            rdata_nxt[CTRL_PROBE_LSB +: 4] = probe_current_code_r;
            rdata_nxt[CTRL_BLANK_LSB +: 4] = blank_code_r;
        end else if (avs_address == REG_CHK_EN) begin
            rdata_nxt[NUM_CH-1:0] = channel_check_enable_r;
        end else if (avs_address == REG_FLAGS) begin
            rdata_nxt[FLG_WARN] = supply_warn_flag_r;
            rdata_nxt[FLG_UNDER] = supply_under_flag_r;
            rdata_nxt[FLG_REF] = ref_flag_r;
            rdata_nxt[FLG_HWARN] = heat_warn_flag_r;
            rdata_nxt[FLG_HPROT] = heat_protect_flag_r;
            rdata_nxt[FLG_RESTART] = restart_flag_r;
            rdata_nxt[FLG_OUT] = out_flag_r;
            rdata_nxt[FLG_GLOBAL] = global_flag_r;
        end else if (avs_address == REG_OPEN) begin
            rdata_nxt[NUM_CH-1:0] = open_load_flag_r;
        end else if (avs_address == REG_STATUS) begin
            rdata_nxt[ST_ERR] = err_pin_oe;
            rdata_nxt[ST_DIAG] = diag_active;
            rdata_nxt[ST_REGUL] = regulator_output;
        end else if (avs_address == REG_RETRY) begin
            rdata_nxt[NUM_CH-1:0] = in_retry;
        end
    end

    assign avs_readdata = rdata_r;
    assign avs_waitrequest = waitreq_r;

    // configuration; held at defaults while the regulator is off [RULE12]
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            group_shutoff_option_r <= 1'b0;
            supply_warn_level_r <= LEVEL_RST;
            probe_current_code_r <= PROBE_RST;
            blank_code_r <= BLANK_RST;
            channel_check_enable_r <= CHK_EN_RST;
        end else if (hshut_s) begin
            group_shutoff_option_r <= 1'b0;
            supply_warn_level_r <= LEVEL_RST;
            probe_current_code_r <= PROBE_RST;
            blank_code_r <= BLANK_RST;
            channel_check_enable_r <= CHK_EN_RST;
        end else if (wr_go && avs_address == REG_CTRL) begin
            if (avs_byteenable[0]) begin
                group_shutoff_option_r <= avs_writedata[CTRL_GROUP_BIT];
            end
            if (avs_byteenable[1]) begin
                supply_warn_level_r <= avs_writedata[CTRL_LEVEL_LSB +: 5];
            end
            if (avs_byteenable[2]) begin
                probe_current_code_r <= avs_writedata[CTRL_PROBE_LSB +: 4];
            end
            if (avs_byteenable[3]) begin
                blank_code_r <= avs_writedata[CTRL_BLANK_LSB +: 4];
            end
        end else if (wr_go && avs_address == REG_CHK_EN) begin
            for (int b = 0; b < 3; b++) begin
                if (avs_byteenable[b]) begin
                    channel_check_enable_r[b*8 +: 8] <= avs_writedata[b*8 +: 8];
                end
            end
        end
    end

    // self-clearing clear bits, high for one cycle after the write [RULE2] [RULE13]
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            fault_clear_r <= 1'b0;
            restart_clear_r <= 1'b0;
        end else begin
            fault_clear_r <= wr_go && avs_address == REG_CTRL && avs_byteenable[0]
                             && avs_writedata[CTRL_FCLR_BIT];
            restart_clear_r <= wr_go && avs_address == REG_CTRL && avs_byteenable[0]
                               && avs_writedata[CTRL_RCLR_BIT];
        end
    end

    // latched flags; a set in the clear cycle wins
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            supply_warn_flag_r <= 1'b0;
            supply_under_flag_r <= 1'b0;
            ref_flag_r <= 1'b0;
            heat_warn_flag_r <= 1'b0;
            heat_protect_flag_r <= 1'b0;
            out_flag_r <= 1'b0;
            open_load_flag_r <= '0;
        end else if (hshut_s) begin
            supply_warn_flag_r <= 1'b0;
            supply_under_flag_r <= 1'b0;
            ref_flag_r <= 1'b0;
            heat_warn_flag_r <= 1'b0;
            heat_protect_flag_r <= 1'b0;
            out_flag_r <= 1'b0;
            open_load_flag_r <= '0;
        end else begin
            supply_warn_flag_r <= warn_r | (supply_warn_flag_r & ~fault_clear_r); // [RULE1]
            supply_under_flag_r <= under_s | (supply_under_flag_r & ~fault_clear_r); // [RULE5]
            ref_flag_r <= ref_s | (ref_flag_r & ~fault_clear_r); // [RULE7]
            heat_warn_flag_r <= hwarn_s | (heat_warn_flag_r & ~fault_clear_r); // [RULE9]
            heat_protect_flag_r <= hprot_s | (heat_protect_flag_r & ~fault_clear_r); // [RULE10]
            out_flag_r <= (|open_set) | (out_flag_r & ~fault_clear_r); // [RULE15]
            open_load_flag_r <= open_set | (open_load_flag_r & ~{NUM_CH{fault_clear_r}});
        end
    end

    // restart and global flags [RULE12] [RULE13]
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            restart_flag_r <= RESTART_FLAG_RST;
            global_flag_r <= RESTART_FLAG_RST;
        end else begin
            restart_flag_r <= hshut_s | (restart_flag_r & ~restart_clear_r);
            global_flag_r <= hshut_s | warn_r | under_s | ref_s | hwarn_s | hprot_s
                             | (|open_set)
                             | (global_flag_r & ~fault_clear_r & ~restart_clear_r);
        end
    end

    // shared retry period counter [RULE16]
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            retry_cnt_r <= '0;
        end else if (retry_cnt_r >= RETRY_CYC - 1) begin
            retry_cnt_r <= '0;
        end else begin
            retry_cnt_r <= retry_cnt_r + 32'h00000001;
        end
    end

    // per-channel open detection and retry
    for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
        wire logic diag_ok = channel_check_enable_r[i] & ~warn_r & ~hshut_s; // [RULE3] [RULE20]
        assign in_retry[i] = st_r[i] == CH_RETRY;
        assign open_set[i] = st_r[i] == CH_RUN && diag_ok && pwm_on[i] && open_r[i]
                             && qual_cnt_r[i] >= qual_lim;
        always_ff @(posedge clk_sys or negedge rstn) begin
            if (!rstn) begin
                st_r[i] <= CH_RUN;
                qual_cnt_r[i] <= '0;
            end else begin
                case (st_r[i])
                    CH_RUN: begin
                        // count only inside the on-time; short pulses restart it [RULE14]
                        if (diag_ok && pwm_on[i] && open_r[i]) begin
                            if (qual_cnt_r[i] >= qual_lim) begin
                                st_r[i] <= CH_RETRY; // [RULE15]
                                qual_cnt_r[i] <= '0;
                            end else begin
                                qual_cnt_r[i] <= qual_cnt_r[i] + 9'h001; // [RULE21]
                            end
                        end else begin
                            qual_cnt_r[i] <= '0;
                        end
                    end
                    CH_RETRY: begin
                        if (!diag_ok) begin
                            st_r[i] <= CH_RUN;
                            qual_cnt_r[i] <= '0;
                        end else if (retry_win && !open_r[i]) begin
                            if (qual_cnt_r[i] >= qual_lim) begin
                                st_r[i] <= CH_RUN; // [RULE18]
                                qual_cnt_r[i] <= '0;
                            end else begin
                                qual_cnt_r[i] <= qual_cnt_r[i] + 9'h001;
                            end
                        end else begin
                            qual_cnt_r[i] <= '0;
                        end
                    end
                    default: begin
                        st_r[i] <= CH_RUN;
                    end
                endcase
            end
        end
    end

    // driver outputs, error pin and regulator
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            chan_enable <= '0;
            retry_pulse <= '0;
            retry_current_num <= PROBE_ADD;
            regulator_output <= 1'b1;
            diag_active <= 1'b0;
            err_pin_o <= 1'b0;
            err_pin_oe <= 1'b0;
        end else begin
            if (all_off) begin
                chan_enable <= '0; // [RULE6] [RULE8] [RULE10] [RULE11]
            end else if (group_shutoff_option_r && any_fault) begin
                chan_enable <= '0; // [RULE19]
            end else begin
                chan_enable <= ~in_retry; // [RULE16]
            end
            retry_pulse <= all_off ? '0 : in_retry & {NUM_CH{retry_win}};
            retry_current_num <= 7'(probe_current_code_r) * PROBE_MUL + PROBE_ADD; // [RULE17]
            regulator_output <= ~hshut_s; // [RULE12]
            diag_active <= ~warn_r; // [RULE3]
            err_pin_o <= 1'b0;
            err_pin_oe <= all_off | any_fault; // [RULE5] [RULE7] [RULE18]
        end
    end

    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    sequence s_write_fclr;
        wr_go && avs_address == REG_CTRL && avs_byteenable[0] && avs_writedata[CTRL_FCLR_BIT];
    endsequence
    sequence s_clear_done;
        ##1 fault_clear_r ##1 !fault_clear_r;
    endsequence
    property p_warn_flag;
        warn_r |=> supply_warn_flag_r && global_flag_r;
    endproperty
    a_warn_flag: assert property (p_warn_flag) else $error("warning flag missing"); // [RULE1]
    property p_clear_pulse;
        s_write_fclr and !hshut_s |-> s_clear_done;
    endproperty
    a_clear_pulse: assert property (p_clear_pulse) else $error("clear bit not one pulse"); // [RULE2]
    property p_under_off;
        under_s |=> chan_enable == '0 && err_pin_oe && supply_under_flag_r;
    endproperty
    a_under_off: assert property (p_under_off) else $error("undervoltage action missing"); // [RULE6]
    property p_ref_off;
        ref_s |=> chan_enable == '0 && err_pin_oe && ref_flag_r && global_flag_r;
    endproperty
    a_ref_off: assert property (p_ref_off) else $error("reference fault action missing"); // [RULE8]
    property p_heat_warn_only;
        hwarn_s && !all_off && !any_fault |=> heat_warn_flag_r && !err_pin_oe;
    endproperty
    a_heat_warn_only: assert property (p_heat_warn_only) else $error("heat warning acted"); // [RULE9]
    property p_shutdown;
        hshut_s |=> !regulator_output && restart_flag_r && err_pin_oe;
    endproperty
    a_shutdown: assert property (p_shutdown) else $error("shutdown action missing"); // [RULE12]
    property p_restart_clear;
        restart_clear_r && !hshut_s |=> !restart_flag_r;
    endproperty
    a_restart_clear: assert property (p_restart_clear) else $error("restart flag kept"); // [RULE13]
    property p_warn_blocks_open;
        warn_r |-> open_set == '0;
    endproperty
    a_warn_blocks_open: assert property (p_warn_blocks_open) else $error("open under warn"); // [RULE3]
    property p_probe_num;
        ##1 retry_current_num == $past(7'(probe_current_code_r)) * PROBE_MUL + PROBE_ADD;
    endproperty
    a_probe_num: assert property (p_probe_num) else $error("retry current wrong"); // [RULE17]
    property p_open_flags;
        |open_set |=> (out_flag_r && global_flag_r) ##1 err_pin_oe;
    endproperty
    a_open_flags: assert property (p_open_flags) else $error("open report missing"); // [RULE15]
    property p_group_off;
        group_shutoff_option_r && any_fault |=> chan_enable == '0;
    endproperty
    a_group_off: assert property (p_group_off) else $error("group shutoff failed"); // [RULE19]
endmodule

// >>> dv/led_load_model.sv
// led string model behind the block's outputs, with a switchable open load
`timescale 1ns/1ns
module led_load_model
    import failsafe_fault_pkg::*;
(
    // drive from the block, and the pwm on-time
    input wire logic [NUM_CH-1:0] chan_enable,
    input wire logic [NUM_CH-1:0] retry_pulse,
    input wire logic [NUM_CH-1:0] pwm_on,
    // load state and comparator
    input wire logic [NUM_CH-1:0] open_mask,
    output logic [NUM_CH-1:0] open_cmp
);
    // an undriven output sits low, so only a driven open string trips the comparator
    assign open_cmp = open_mask & ((chan_enable & pwm_on) | retry_pulse);
endmodule

// >>> dv/testbench.sv
// self-checking bench of the fail-safe fault manager
`timescale 1ns/1ns
module testbench
    import failsafe_fault_pkg::*;
;
    localparam int RCYC = 600;
    localparam int QUAL = OPEN_DEG_CYC;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic [4:0] adr = 5'h00;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic wtq;
    logic [5:0] volts = 6'h0C;
    logic [5:0] flt = 6'h00;
    logic [23:0] pwm = 24'hFFFFFF;
    logic [23:0] mask = 24'h000000;
    logic [23:0] cmp, en, rp;
    logic [6:0] num;
    logic reg_on, diag, erro, erroe, rp3_q;
    int failures = 0;
    int cmp_count = 0;
    int cyc = 0;
    int rises = 0;

    failsafe_fault_manager #(.RETRY_CYC(RCYC)) i_dut (
        .clk_sys(clk_sys), .rstn(rstn), .avs_address(adr), .avs_read(rd),
        .avs_write(wr), .avs_writedata(wdat), .avs_byteenable(4'hF),
        .avs_readdata(rdat), .avs_waitrequest(wtq), .supply_volts(volts),
        .supply_under_det(flt[0]), .ref_open_det(flt[1]), .ref_short_det(flt[2]),
        .heat_warn_det(flt[3]), .heat_protect_det(flt[4]), .heat_shutdown_det(flt[5]),
        .open_cmp(cmp), .pwm_on(pwm), .chan_enable(en), .retry_pulse(rp),
        .retry_current_num(num), .regulator_output(reg_on), .diag_active(diag),
        .err_pin_o(erro), .err_pin_oe(erroe));
    led_load_model i_load (.chan_enable(en), .retry_pulse(rp), .pwm_on(pwm),
        .open_mask(mask), .open_cmp(cmp));

    initial begin
        forever #50 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        rp3_q <= rp[3];
        if (rp[3] && !rp3_q) rises <= rises + 1;
        if (cyc == 40000) begin
            failures = failures + 1;
            test_done;
        end
    end

    task automatic test_done;
        if (failures == 0 && cmp_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wait_n(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    // one avalon transfer, held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        @(posedge clk_sys);
        adr <= a;
        wdat <= d;
        rd <= !w;
        wr <= w;
        do begin
            @(posedge clk_sys);
        end while (wtq !== 1'b0);
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic wr32(input logic [4:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rd_chk(input logic [4:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(q, exp);
    endtask

    task automatic t_reset;
        chk(num, 32'h4);
        chk(erro, 32'h0);
        rd_chk(REG_FLAGS, 32'hA0);
        rd_chk(REG_CHK_EN, 32'hFFFFFF);
        rd_chk(REG_STATUS, 32'h6);
        rd_chk(5'h18, 32'h0);
        wr32(5'h18, 32'hFFFFFFFF);
        rd_chk(REG_FLAGS, 32'hA0);
        wr32(REG_CTRL, 32'h2);
        rd_chk(REG_FLAGS, 32'h0);
        rd_chk(REG_CTRL, 32'h0);
    endtask
    task automatic t_fault(input int idx, input logic [31:0] fl, input logic off);
        flt[idx] <= 1'b1;
        wait_n(6);
        chk(en, off ? 32'h0 : 32'hFFFFFF);
        chk(erroe, off);
        flt[idx] <= 1'b0;
        wait_n(6);
        chk(en, 32'hFFFFFF);
        chk(erroe, 32'h0);
        rd_chk(REG_FLAGS, fl);
        wr32(REG_CTRL, 32'h1);
        rd_chk(REG_FLAGS, 32'h0);
    endtask
    task automatic t_low;
        wr32(REG_CTRL, 32'h800);
        volts <= 6'h0B;
        wait_n(6);
        chk(diag, 32'h0);
        rd_chk(REG_FLAGS, 32'h81);
        volts <= 6'h0C;
        wait_n(6);
        chk(diag, 32'h1);
        rd_chk(REG_FLAGS, 32'h81);
        wr32(REG_CTRL, 32'h1F00);
        volts <= 6'h22;
        wait_n(6);
        chk(diag, 32'h0);
        volts <= 6'h23;
        wait_n(6);
        chk(diag, 32'h1);
        wr32(REG_CTRL, 32'h1);
        volts <= 6'h0C;
    endtask
    task automatic t_open;
        int r0;
        mask <= 24'h000008;
        wait_n(QUAL + 10);
        chk(en, 32'hFFFFF7);
        chk(erroe, 32'h1);
        rd_chk(REG_OPEN, 32'h8);
        rd_chk(REG_FLAGS, 32'hC0);
        rd_chk(REG_RETRY, 32'h8);
        wr32(REG_CTRL, 32'hF0000);
        wait_n(2);
        chk(num, 32'h40);
        r0 = rises;
        wait_n(3 * RCYC);
        chk(rises - r0, 32'h3);
        mask <= 24'h000000;
        wait_n(2 * RCYC);
        chk(en, 32'hFFFFFF);
        chk(erroe, 32'h0);
        rd_chk(REG_OPEN, 32'h8);
        wr32(REG_CTRL, 32'h1);
        rd_chk(REG_OPEN, 32'h0);
    endtask
    task automatic t_group;
        wr32(REG_CTRL, 32'h01000004);
        mask <= 24'h000020;
        wait_n(QUAL + 8);
        chk(en, 32'hFFFFFF);
        wait_n(12);
        chk(en, 32'h0);
        mask <= 24'h000000;
        wait_n(2 * RCYC);
        chk(en, 32'hFFFFFF);
        wr32(REG_CTRL, 32'h1);
    endtask
    task automatic t_nochk;
        wr32(REG_CHK_EN, 32'hFFFF7F);
        mask <= 24'h000080;
        wait_n(QUAL + 10);
        chk(en, 32'hFFFFFF);
        chk(erroe, 32'h0);
        rd_chk(REG_OPEN, 32'h0);
        rd_chk(REG_FLAGS, 32'h0);
        mask <= 24'h000000;
        wr32(REG_CHK_EN, 32'hFFFFFF);
    endtask
    // pulses half as long as the qualification time must never report
    task automatic t_short;
        mask <= 24'h000004;
        repeat (4) begin
            pwm <= 24'h000000;
            wait_n(QUAL / 2);
            pwm <= 24'hFFFFFF;
            wait_n(QUAL / 2);
        end
        pwm <= 24'h000000;
        wait_n(4);
        chk(en, 32'hFFFFFF);
        rd_chk(REG_FLAGS, 32'h0);
        mask <= 24'h000000;
        pwm <= 24'hFFFFFF;
    endtask
    task automatic t_shut;
        wr32(REG_CTRL, 32'h800);
        flt[5] <= 1'b1;
        wait_n(6);
        chk(reg_on, 32'h0);
        chk(erroe, 32'h1);
        flt[5] <= 1'b0;
        wait_n(6);
        chk(reg_on, 32'h1);
        chk(erroe, 32'h0);
        rd_chk(REG_CTRL, 32'h0);
        rd_chk(REG_FLAGS, 32'hA0);
        wr32(REG_CTRL, 32'h2);
        rd_chk(REG_FLAGS, 32'h0);
    endtask

    initial begin
        wait_n(12);
        rstn <= 1'b1;
        wait_n(2);
        t_reset;
        t_fault(0, 32'h82, 1'b1);
        t_fault(1, 32'h84, 1'b1);
        t_fault(2, 32'h84, 1'b1);
        t_fault(3, 32'h88, 1'b0);
        t_fault(4, 32'h90, 1'b1);
        t_low;
        t_open;
        t_group;
        t_nochk;
        t_short;
        t_shut;
        test_done;
    end
endmodule
